// >>> rtl/opaddr_pkg.sv
package opaddr_pkg;
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 8;
  localparam int NUM_BANKS   = 4;
  localparam int REGS_PER_BK = 8;
  // register codes within a bank: X A C B E D L H
  localparam logic [2:0] REG_C = 3'h2;
  localparam logic [2:0] REG_B = 3'h3;
  localparam logic [2:0] REG_E = 3'h4;
  localparam logic [2:0] REG_D = 3'h5;
  localparam logic [2:0] REG_L = 3'h6;
  localparam logic [2:0] REG_H = 3'h7;
  // internal high-speed RAM window for the stack
  localparam logic [15:0] HSRAM_LO = 16'hFE20;
  localparam logic [15:0] HSRAM_HI = 16'hFEFF;
  localparam logic [15:0] ADDR_RST = 16'h0000;

  typedef enum logic [2:0] {
    MODE_IND_SECOND,
    MODE_IND_BASE,
    MODE_BASED,
    MODE_IDX_B,
    MODE_IDX_C,
    MODE_STACK
  } mode_t;

  typedef struct packed {
    logic        valid;
    mode_t       mode;
    logic [7:0]  disp;
    logic [2:0]  reg_code;
  } addr_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic        stack_fault;
    logic [7:0]  reg_data;
  } addr_resp_t;
endpackage : opaddr_pkg

// >>> rtl/operand_address_generator.sv
`timescale 1ns/1ps
module operand_address_generator (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // bank selection
  input  wire logic                   bank_select_bit0,
  input  wire logic                   bank_select_bit1,
  // register bank contents, all four banks flattened
  input  wire logic [4*8*8-1:0]       bank_regs,
  input  wire logic [15:0]            stack_top_pointer,
  // request from decode
  input  wire opaddr_pkg::addr_req_t  req,
  // answer to memory access path
  output opaddr_pkg::addr_resp_t      resp
);

  logic [1:0]             bank_idx;
  logic [63:0]            bank_vec;
  logic [7:0]             base_hi;
  logic [7:0]             base_lo;
  logic [7:0]             second_hi;
  logic [7:0]             second_lo;
  logic [7:0]             index_upper;
  logic [7:0]             index_lower;
  logic [7:0]             reg_nxt;
  logic [15:0]            base_register_pair;
  logic [15:0]            second_pointer_pair;
  logic [15:0]            addr_nxt;
  logic                   fault_nxt;
  opaddr_pkg::addr_resp_t resp_r;

  assign bank_idx = {bank_select_bit1, bank_select_bit0};

  // every pair read below comes from this one bank
  lane_mux #(
    .LANE_W (opaddr_pkg::REGS_PER_BK * opaddr_pkg::DATA_W),
    .LANES  (opaddr_pkg::NUM_BANKS)
  ) i_lane_mux_bank (
    .sel   (bank_idx),
    .lanes (bank_regs),
    .lane  (bank_vec)
  );

  lane_mux i_lane_mux_base_hi (
    .sel   (opaddr_pkg::REG_H),
    .lanes (bank_vec),
    .lane  (base_hi)
  );

  lane_mux i_lane_mux_base_lo (
    .sel   (opaddr_pkg::REG_L),
    .lanes (bank_vec),
    .lane  (base_lo)
  );

  lane_mux i_lane_mux_second_hi (
    .sel   (opaddr_pkg::REG_D),
    .lanes (bank_vec),
    .lane  (second_hi)
  );

  lane_mux i_lane_mux_second_lo (
    .sel   (opaddr_pkg::REG_E),
    .lanes (bank_vec),
    .lane  (second_lo)
  );

  lane_mux i_lane_mux_index_upper (
    .sel   (opaddr_pkg::REG_B),
    .lanes (bank_vec),
    .lane  (index_upper)
  );

  lane_mux i_lane_mux_index_lower (
    .sel   (opaddr_pkg::REG_C),
    .lanes (bank_vec),
    .lane  (index_lower)
  );

  // 3-bit opcode field picks one of eight registers
  lane_mux i_lane_mux_reg (
    .sel   (req.reg_code),
    .lanes (bank_vec),
    .lane  (reg_nxt)
  );

  assign base_register_pair  = {base_hi, base_lo};
  assign second_pointer_pair = {second_hi, second_lo};

  always_comb begin
    fault_nxt = 1'b0;
    case (req.mode)
      opaddr_pkg::MODE_IND_SECOND: addr_nxt = second_pointer_pair;
      opaddr_pkg::MODE_IND_BASE: addr_nxt = base_register_pair;
      // 17-bit sum cut to 16 bits drops the carry
      opaddr_pkg::MODE_BASED: addr_nxt = 16'(base_register_pair + {8'h00, req.disp});
      opaddr_pkg::MODE_IDX_B: addr_nxt = 16'(base_register_pair
                                 + {8'h00, index_upper});
      opaddr_pkg::MODE_IDX_C: addr_nxt = 16'(base_register_pair
                                 + {8'h00, index_lower});
      opaddr_pkg::MODE_STACK: begin
        addr_nxt  = stack_top_pointer;
        // out-of-window pointer is flagged rather than passed silently
        fault_nxt = (stack_top_pointer < opaddr_pkg::HSRAM_LO)
                 || (stack_top_pointer > opaddr_pkg::HSRAM_HI);
      end
      default: addr_nxt = opaddr_pkg::ADDR_RST;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resp_r <= '0;
    end else begin
      resp_r.valid       <= req.valid;
      resp_r.addr        <= addr_nxt;
      resp_r.stack_fault <= req.valid & fault_nxt;
      resp_r.reg_data    <= reg_nxt;
    end
  end

  assign resp = resp_r;

  property p_based_sum;
    @(posedge clk) disable iff (!reset_n)
      (req.valid && req.mode == opaddr_pkg::MODE_BASED)
      |=> resp.addr == 16'($past(base_register_pair) + {8'h00, $past(req.disp)});
  endproperty
  a_based_sum: assert property (p_based_sum) else $error("based sum wrong");

  property p_ind_second;
    @(posedge clk) disable iff (!reset_n)
      (req.valid && req.mode == opaddr_pkg::MODE_IND_SECOND)
      |=> resp.valid && resp.addr == $past(second_pointer_pair);
  endproperty
  a_ind_second: assert property (p_ind_second) else $error("indirect address wrong");

  property p_idx_c;
    @(posedge clk) disable iff (!reset_n)
      (req.valid && req.mode == opaddr_pkg::MODE_IDX_C)
      |=> resp.addr == 16'($past(base_register_pair) + {8'h00, $past(bank_vec[23:16])});
  endproperty
  a_idx_c: assert property (p_idx_c) else $error("indexed sum wrong");

  property p_stack;
    @(posedge clk) disable iff (!reset_n)
      (req.valid && req.mode == opaddr_pkg::MODE_STACK)
      |=> resp.addr == $past(stack_top_pointer)
          && resp.stack_fault == ($past(stack_top_pointer) < opaddr_pkg::HSRAM_LO
                                  || $past(stack_top_pointer) > opaddr_pkg::HSRAM_HI);
  endproperty
  a_stack: assert property (p_stack) else $error("stack address wrong");

  property p_no_fault;
    @(posedge clk) disable iff (!reset_n)
      (req.mode != opaddr_pkg::MODE_STACK) |=> !resp.stack_fault;
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("spurious stack fault");

  property p_ind_base;
    @(posedge clk) disable iff (!reset_n)
      (req.valid && req.mode == opaddr_pkg::MODE_IND_BASE)
      |=> resp.valid && resp.addr == $past(base_register_pair);
  endproperty
  a_ind_base: assert property (p_ind_base) else $error("base indirect address wrong");

  property p_idx_b;
    @(posedge clk) disable iff (!reset_n)
      (req.valid && req.mode == opaddr_pkg::MODE_IDX_B)
      |=> resp.addr == 16'($past(base_register_pair) + {8'h00, $past(bank_vec[31:24])});
  endproperty
  a_idx_b: assert property (p_idx_b) else $error("upper indexed sum wrong");

  // bank pick checked against the flat input, not the lane mux
  property p_bank_pick;
    @(posedge clk) disable iff (!reset_n)
      (req.valid && req.mode == opaddr_pkg::MODE_IND_BASE)
      |=> resp.addr == 16'($past(bank_regs) >> (64 * $past(bank_idx) + 48));
  endproperty
  a_bank_pick: assert property (p_bank_pick) else $error("wrong register bank");

  property p_reg_pick;
    @(posedge clk) disable iff (!reset_n)
      req.valid |=> resp.reg_data == 8'($past(bank_vec) >> (8 * $past(req.reg_code)));
  endproperty
  a_reg_pick: assert property (p_reg_pick) else $error("register operand wrong");

  property p_valid_follow;
    @(posedge clk) disable iff (!reset_n)
      req.valid |=> resp.valid;
  endproperty
  a_valid_follow: assert property (p_valid_follow) else $error("answer missing");

  property p_idle_quiet;
    @(posedge clk) disable iff (!reset_n)
      !req.valid |=> !resp.valid && !resp.stack_fault;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("answer without request");

  // undecoded modes park the address at zero
  property p_undef_mode;
    @(posedge clk) disable iff (!reset_n)
      (req.mode > opaddr_pkg::MODE_STACK) |=> resp.addr == opaddr_pkg::ADDR_RST;
  endproperty
  a_undef_mode: assert property (p_undef_mode) else $error("undecoded mode address");

endmodule : operand_address_generator

// one lane out of a flat vector, shared by the bank and register picks
module lane_mux #(
  parameter int LANE_W = 8,
  parameter int LANES  = 8
) (
  // lane index
  input  wire logic [$clog2(LANES)-1:0] sel,
  // lane n sits at [n*LANE_W +: LANE_W]
  input  wire logic [LANES*LANE_W-1:0]  lanes,
  // chosen lane
  output logic      [LANE_W-1:0]        lane
);

  always_comb begin
    lane = lanes[sel*LANE_W +: LANE_W];
  end

endmodule : lane_mux

// >>> test/bank_model.sv
`timescale 1ns/1ps
module bank_model (
  // byte per register code
  input  wire logic [63:0]  bank_bytes,
  // four banks flattened
  output logic      [255:0] bank_regs
);
  // each bank offset so a wrong bank pick shows
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      bank_regs[i*8+:8] = bank_bytes[(i%8)*8+:8] + 8'(i / 8 * 17);
    end
  end
endmodule : bank_model

// >>> test/operand_address_generator_tb.sv
`timescale 1ns/1ps
module operand_address_generator_tb;
  logic                   clk = 0;
  logic                   reset_n = 0;
  logic [1:0]             bank = 2'h0;
  logic [63:0]            bank_bytes = 64'hFFF8_1234_C080_0000;
  logic [15:0]            stack_ptr = 16'h0000;
  logic [255:0]           regs;
  opaddr_pkg::addr_req_t  req = '0;
  opaddr_pkg::addr_resp_t resp;
  int                     fails = 0;
  int                     checks_done = 0;
  always #2.5 clk = ~clk;
  bank_model i_bank_model (.bank_bytes(bank_bytes), .bank_regs(regs));
  operand_address_generator i_operand_address_generator (.clk(clk), .reset_n(reset_n),
    .bank_select_bit0(bank[0]), .bank_select_bit1(bank[1]), .bank_regs(regs),
    .stack_top_pointer(stack_ptr), .req(req), .resp(resp));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [7:0] rv(int k);
    return bank_bytes[k*8+:8] + 8'(int'(bank) * 17);
  endfunction : rv
  task automatic tally_and_finish();
    if (fails == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // one request per call, answer checked one cycle later
  task automatic access(int b, int m, logic [7:0] d, logic [2:0] c, logic [15:0] s);
    logic [15:0] base;
    logic [15:0] ea;
    logic        flt;
    @(posedge clk);
    bank      <= 2'(b);
    stack_ptr <= s;
    req       <= '{1'b1, opaddr_pkg::mode_t'(m), d, c};
    @(posedge clk);
    #1;
    base = {rv(7), rv(6)};
    flt  = (m == 5) && (s < opaddr_pkg::HSRAM_LO || s > opaddr_pkg::HSRAM_HI);
    case (m)
      0: ea = {rv(5), rv(4)};
      1: ea = base;
      2: ea = base + {8'h00, d};
      3: ea = base + {8'h00, rv(3)};
      4: ea = base + {8'h00, rv(2)};
      5: ea = s;
      default: ea = opaddr_pkg::ADDR_RST;
    endcase
    check("valid", 32'(resp.valid), 32'h1);
    check("addr", 32'(resp.addr), 32'(ea));
    check("fault", 32'(resp.stack_fault), 32'(flt));
    check("reg", 32'(resp.reg_data), 32'(rv(int'(c))));
  endtask : access
  // answer held clear through reset, first request right after release
  task automatic reset_state();
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    check("reset", 32'(resp), 32'h0);
  endtask : reset_state
  // every mode in every bank; modes 6 and 7 park at address zero
  task automatic mode_sweep();
    for (int b = 0; b < 4; b++) begin
      for (int m = 0; m < 8; m++) begin
        access(b, m, b[0] ? 8'hFF : 8'h10, 3'(m + b), 16'hFE1F + 16'(b * 16'h0070));
      end
    end
  endtask : mode_sweep
  // reset under a live request clears at once, request resumes after release
  task automatic mid_reset();
    @(posedge clk);
    stack_ptr <= 16'hFE20;
    req       <= '{1'b1, opaddr_pkg::MODE_STACK, 8'h00, 3'h0};
    @(posedge clk);
    reset_n <= 1'b0;
    #1;
    check("mid reset", 32'(resp), 32'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    check("resume valid", 32'(resp.valid), 32'h1);
    check("resume addr", 32'(resp.addr), 32'hFE20);
    check("resume fault", 32'(resp.stack_fault), 32'h0);
  endtask : mid_reset
  // dropping valid ends the answer on the next edge
  task automatic idle_drop();
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    #1;
    check("idle", 32'(resp.valid), 32'h0);
  endtask : idle_drop
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
  initial begin
    reset_state();
    mode_sweep();
    mid_reset();
    idle_drop();
    tally_and_finish();
  end
endmodule : operand_address_generator_tb
